// ===== dpllpl_detect.sv
// phase-loss detection and relock mode selection of the digital loop
//
// Notes on behaviour
// - window check off: no phase-error loss
// - window check on: error beyond window means loss while the reference is active
// - bit clear: inactivity keeps lock, nearest-edge relock
// - phase loss starts full 360-degree acquisition
// - register read/write, resets to 1010 0010
`timescale 1ns/100ps
`include "dpllpl_params.svh"
module dpllpl_detect (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic [`DPLLPL_ERR_W-1:0] i_phase_err,
  input wire logic i_ref_active,
  input wire logic i_other_loss,
  input wire logic i_acq_done,
  output logic o_phase_loss,
  output logic [1:0] o_mode
);
  // ----------------------------------------
  // configuration register
  // ----------------------------------------
  logic [7:0] ctrl;

  dpllpl_ctrl_reg u_reg (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_wr(i_wr),
    .i_wdata(i_wdata),
    .o_rdata(ctrl)
  );

  assign o_rdata = ctrl;

  // ----------------------------------------
  // window and loss decision
  // ----------------------------------------
  // window grows linearly with the code; code 0 gives a zero window
  function automatic logic [`DPLLPL_ERR_W-1:0] win_limit(
    input logic [2:0] code
  );
    logic [`DPLLPL_ERR_W-1:0] lim;
    lim = `DPLLPL_ERR_W'(code) * `DPLLPL_STEP;
    return lim;
  endfunction : win_limit

  typedef struct packed {
    logic loss;
    dpllpl_pkg::dpllpl_mode_t mode;
  } dpllpl_st_t;

  dpllpl_st_t st;
  dpllpl_st_t next_st;
  logic [`DPLLPL_ERR_W-1:0] abs_err;
  logic win_viol;
  logic inact_loss;
  logic loss_now;

  always_comb begin
    // error is two's complement; take magnitude
    abs_err = i_phase_err[`DPLLPL_ERR_W-1] ?
              `DPLLPL_ERR_W'(-i_phase_err) : i_phase_err;
    // a dead reference yields no usable error, so it must not unlock
    win_viol = ctrl[`DPLLPL_WIN_EN_BIT] && i_ref_active &&
               (abs_err > win_limit(ctrl[2:0]));
    inact_loss = ctrl[`DPLLPL_INACT_BIT] && !i_ref_active;
    loss_now = win_viol || inact_loss || i_other_loss;
  end

  always_comb begin
    next_st = st;
    next_st.loss = loss_now;
    case (st.mode)
      dpllpl_pkg::DPLLPL_LOCKED: begin
        if (loss_now) begin
          next_st.mode = dpllpl_pkg::DPLLPL_ACQUIRE;
        end else if (!i_ref_active) begin
          // hold lock over missing cycles
          next_st.mode = dpllpl_pkg::DPLLPL_NEAREST;
        end
      end
      dpllpl_pkg::DPLLPL_NEAREST: begin
        if (loss_now) begin
          next_st.mode = dpllpl_pkg::DPLLPL_ACQUIRE;
        end else if (i_ref_active) begin
          next_st.mode = dpllpl_pkg::DPLLPL_LOCKED;
        end
      end
      dpllpl_pkg::DPLLPL_ACQUIRE: begin
        // stay in acquisition until loss clears and loop reports done
        if (!loss_now && i_acq_done) begin
          next_st.mode = dpllpl_pkg::DPLLPL_LOCKED;
        end
      end
      default: begin
        next_st.mode = dpllpl_pkg::DPLLPL_ACQUIRE;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st.loss <= 1'b1;
      st.mode <= dpllpl_pkg::DPLLPL_ACQUIRE;
    end else begin
      st <= next_st;
    end
  end

  assign o_phase_loss = st.loss;
  assign o_mode = st.mode;
endmodule : dpllpl_detect

// ===== dpllpl_params.svh
// constants for the phase-loss detection configuration block
`ifndef DPLLPL_PARAMS_SVH
`define DPLLPL_PARAMS_SVH
`define DPLLPL_WIN_EN_BIT 7
`define DPLLPL_INACT_BIT 6
`define DPLLPL_NARROW_BIT 5
`define DPLLPL_SIZE_LSB 0
`define DPLLPL_SIZE_MSB 2
`define DPLLPL_CTRL_RESET 8'hA2
`define DPLLPL_CTRL_WMASK 8'hE7
`define DPLLPL_ERR_W 12
`define DPLLPL_STEP 12'h040
`define DPLLPL_HALF_CYCLE 12'h800
`define DPLLPL_FULL_CYCLE 12'hFFF
`endif

// ===== dpllpl_pkg.sv
// types for the phase-loss detection configuration block
package dpllpl_pkg;
  typedef enum logic [1:0] {
    DPLLPL_LOCKED = 2'b00,
    DPLLPL_NEAREST = 2'b01,
    DPLLPL_ACQUIRE = 2'b10
  } dpllpl_mode_t;
endpackage : dpllpl_pkg

// ===== dpllpl_ctrl_reg.sv
// phase-loss window control register with its reset value
`timescale 1ns/100ps
`include "dpllpl_params.svh"
module dpllpl_ctrl_reg (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  typedef struct packed {
    logic [7:0] ctrl;
  } dpllpl_reg_st_t;

  dpllpl_reg_st_t st;
  dpllpl_reg_st_t next_st;

  always_comb begin
    next_st = st;
    // unused bits [4:3] hold zero
    if (i_wr) begin
      next_st.ctrl = i_wdata & `DPLLPL_CTRL_WMASK;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st.ctrl <= `DPLLPL_CTRL_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.ctrl;
endmodule : dpllpl_ctrl_reg

// ===== dpllpl_ref_model.sv
// reference model: activity and phase error seen by the loop
`timescale 1ns/100ps
module dpllpl_ref_model(
  input wire logic i_gone,
  input wire logic [11:0] i_err,
  output logic o_active,
  output logic [11:0] o_err
);
  // a dead source gives no valid error, so the measure is scrambled
  assign o_active = !i_gone;
  assign o_err = i_gone ? ~i_err : i_err;
endmodule : dpllpl_ref_model

// ===== dpllpl_sva.sv
// checker for phase-loss detection
`timescale 1ns/100ps
module dpllpl_sva(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic [11:0] i_phase_err,
  input wire logic i_ref_active,
  input wire logic i_other_loss,
  input wire logic i_acq_done,
  input wire logic o_phase_loss,
  input wire logic [1:0] o_mode
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire [11:0] m = i_phase_err[11] ? -i_phase_err : i_phase_err;
  wire l = o_rdata[7] && i_ref_active && m > {o_rdata[2:0], 6'h00}
    || o_rdata[6] && !i_ref_active || i_other_loss;
  sequence s_loss; l; endsequence
  a_loss_flag: assert property (
    s_loss |=> o_phase_loss && o_mode == 2)
    else $error("loss missed");
  a_no_loss: assert property (!l |=> !o_phase_loss)
    else $error("false loss");
  a_reg_write: assert property (
    i_wr |=> o_rdata == ($past(i_wdata) & 8'hE7))
    else $error("bad write");
  a_reg_hold: assert property (!i_wr |=> $stable(o_rdata))
    else $error("reg moved");
  a_near_edge: assert property (
    o_mode == 0 && !i_ref_active && !l |=> o_mode == 1)
    else $error("no hold");
  a_hold_exit: assert property (
    o_mode == 1 && i_ref_active && !l |=> o_mode == 0)
    else $error("no return");
  a_acq_end: assert property (
    o_mode == 2 && !l && i_acq_done |=> o_mode == 0)
    else $error("no relock");
endmodule : dpllpl_sva
bind dpllpl_detect dpllpl_sva sva_u(
  .i_clk(i_clk),
  .i_rst(i_rst),
  .i_wr(i_wr),
  .i_wdata(i_wdata),
  .o_rdata(o_rdata),
  .i_phase_err(i_phase_err),
  .i_ref_active(i_ref_active),
  .i_other_loss(i_other_loss),
  .i_acq_done(i_acq_done),
  .o_phase_loss(o_phase_loss),
  .o_mode(o_mode)
);

// ===== dpllpl_detect_test.sv
// self-checking bench for the phase-loss detection block
`timescale 1ns/100ps
module dpllpl_detect_test;
  logic i_clk = 0, i_rst = 1, i_wr = 0, g = 0, i_other_loss = 0;
  logic i_acq_done = 0, act, o_phase_loss, x;
  logic [7:0] i_wdata = 8'h00, o_rdata, r = 8'hA2;
  logic [11:0] e = 12'h000, ph;
  logic [1:0] o_mode;
  logic [1:0] md = 2'h2;
  int err_total = 0, n_compared = 0;
  always #50 i_clk = ~i_clk;
  dpllpl_ref_model ref_u(.i_gone(g), .i_err(e), .o_active(act), .o_err(ph));
  dpllpl_detect dut_u(.i_clk, .i_rst, .i_wr, .i_wdata, .o_rdata,
    .i_phase_err(ph), .i_ref_active(act), .i_other_loss, .i_acq_done,
    .o_phase_loss, .o_mode);
  function automatic logic loss_of(logic [7:0] c, logic [11:0] v);
    logic [11:0] m;
    m = v[11] ? -v : v;
    return c[7] && act && m > {c[2:0], 6'h00} || c[6] && !act
      || i_other_loss;
  endfunction : loss_of
  // expected relock mode one cycle on: 0 locked, 1 nearest, 2 acquire
  function automatic logic [1:0] mode_of(logic [1:0] m, logic l);
    if (l) return 2'h2;
    if (m == 2'h0 && !act) return 2'h1;
    if (m == 2'h1 && act) return 2'h0;
    if (m == 2'h2 && i_acq_done) return 2'h0;
    return m;
  endfunction : mode_of
  task automatic chk(logic [7:0] s, logic [7:0] w);
    n_compared++;
    if (s !== w) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, s, w);
    end
  endtask : chk
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    void'($urandom(40170));
    repeat (16) @(negedge i_clk);
    chk(o_rdata, 8'hA2);
    chk({o_phase_loss, o_mode}, 8'h06);
    i_rst = 0;
    repeat (600) begin
      i_wr = $urandom % 4 == 0;
      i_wdata = $urandom;
      // window edge and the most negative error are the awkward cases
      e = $urandom % 2 ? $urandom : {r[2:0], 6'h00} + $urandom % 2;
      if ($urandom % 9 == 0) e = 12'h800;
      g = $urandom % 8 == 0;
      i_other_loss = $urandom % 16 == 0;
      i_acq_done = $urandom;
      #1 x = loss_of(r, ph);
      md = mode_of(md, x);
      if (i_wr) r = i_wdata & 8'hE7;
      @(negedge i_clk);
      chk(o_rdata, r);
      chk(o_phase_loss, x);
      if (x) chk(o_mode, 2'h2);
      chk(o_mode, md);
    end
    wrap_up();
  end
  initial begin
    #70000;
    err_total++;
    wrap_up();
  end
endmodule : dpllpl_detect_test
